// *** core/rst_pwr_ctrl.sv ***
// reset sources, self-clearing reset bits, ready flag, eeprom probe and phy power-down
// Operation
// - phy general power-down held while bit 0.11 high; management stays alive
// - clearing 0.11 powers phy up and then resets it automatically
// - bit 17.13 set enables energy-detect power-down; clear disables it
// - energy-detect with no line energy powers phy down except detect logic
// - no transmission while line energy is low in energy-detect mode
// - line energy wakes phy, restores state, sets energy wake flag
// - enabled energy wake flag raises host interrupt; first packets may be lost
// - por and pin reset reset everything, reload mac, latch straps
// - host soft reset resets bus, mac layer, mac; reloads mac address
// - after por, pin or soft reset, probe eeprom with busy flag set
// - power-up timer holds internal reset about 22 ms
// - ready reads zero until power-on reset completes, then set
// - low reset pin starts hardware reset; ready zero until done
// - wake write from power-down sets ready within 2 ms
// - hardware config bit 0 starts host soft reset, self-clears after 2 us
// - power control bit 10 starts phy soft reset, self-clears after 100 us
// - phy control bit 15 starts phy soft reset, self-clears when done
// - any wake test write in sleep returns to normal; host writes nothing else
`timescale 1ns/1ps
`include "rst_pwr_cfg.svh"
module rst_pwr_ctrl
  #(parameter int POR_CYCLES  = `POR_CYCLES,
    parameter int WAKE_CYCLES = `WAKE_CYCLES)
  (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // external pins, asynchronous
  input  wire logic hw_reset_input_n,
  input  wire logic line_energy_pin,
  input  wire logic strap_pins,
  // host control strobes, one cycle
  input  wire logic host_soft_reset_bit,
  input  wire logic phy_rst_write,
  input  wire logic phy_ctl_rst_write,
  input  wire logic wake_test_write,
  input  wire logic sleep_request,
  input  wire logic energy_flag_clear,
  // host control levels
  input  wire logic phy_pdn_bit,
  input  wire logic ed_pdn_bit,
  input  wire logic energy_int_enable,
  // reset outputs, active low
  output logic      hbi_rst_n,
  output logic      mil_rst_n,
  output logic      mac_rst_n,
  output logic      pll_rst_n,
  output logic      exempt_rst_n,
  output logic      phy_rst_n,
  // phy power
  output logic      phy_powered,
  output logic      phy_tx_enable,
  // status
  output logic      ready,
  output logic      host_soft_reset_bit_rd,
  output logic      phy_rst_bit_rd,
  output logic      phy_ctl_rst_bit_rd,
  output logic      eeprom_busy_flag,
  output logic      mac_addr_reload,
  output logic      strap_latched,
  output logic      energy_wake_int_flag,
  output logic      energy_irq
  );

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    rst_pwr_pkg::seq_state_t seq;
    rst_pwr_pkg::phy_state_t phy;
    logic [`CNT_W-1:0]       seq_cnt;
    logic [`CNT_W-1:0]       phy_cnt;
    logic [7:0]              ee_cnt;
    logic                    host_soft_reset_bit_bit;
    logic                    pmc_rst_bit;
    logic                    ctl_rst_bit;
    logic                    ee_busy;
    logic                    reload;
    logic                    strap;
    logic                    energy_flag;
    logic                    irq;
    logic                    ready;
    logic                    hbi_rst_n;
    logic                    pll_rst_n;
    logic                    phy_rst_n;
    logic                    powered;
    logic                    tx_en;
    logic                    energy_prev;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   pin_n_sync;
  logic   energy_sync;
  logic   strap_sync;

  // pin release waits two clocks, so reset never drops mid-cycle
  sync_2ff #(.RST_VAL(1'b0)) u_sync_rst (
    .clock (clock),
    .nrst  (nrst),
    .d     (hw_reset_input_n),
    .q     (pin_n_sync)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_energy (
    .clock (clock),
    .nrst  (nrst),
    .d     (line_energy_pin),
    .q     (energy_sync)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_strap (
    .clock (clock),
    .nrst  (nrst),
    .d     (strap_pins),
    .q     (strap_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next         = state_reg;
    state_next.reload  = 1'b0;
    state_next.energy_prev = energy_sync;

    // eeprom probe runs down independently of the sequencer
    if (state_reg.ee_busy)
    begin
      if (state_reg.ee_cnt == 8'h00)
        state_next.ee_busy = 1'b0;
      else
        state_next.ee_cnt = state_reg.ee_cnt - 8'h01;
    end

    case (state_reg.seq)
      rst_pwr_pkg::st_por:
      begin
        // whole chip held, including pll and phy
        state_next.ready     = 1'b0;
        state_next.hbi_rst_n = 1'b0;
        state_next.pll_rst_n = 1'b0;
        state_next.phy_rst_n = 1'b0;
        state_next.phy       = rst_pwr_pkg::phy_in_reset;
        if (state_reg.seq_cnt == `CNT_W'(POR_CYCLES - 1))
        begin
          state_next.seq       = rst_pwr_pkg::st_idle;
          state_next.ready     = 1'b1;
          state_next.hbi_rst_n = 1'b1;
          state_next.pll_rst_n = 1'b1;
          state_next.phy_rst_n = 1'b1;
          state_next.phy       = rst_pwr_pkg::phy_on;
          state_next.strap     = strap_sync;
          state_next.reload    = 1'b1;
          state_next.ee_busy   = 1'b1;
          state_next.ee_cnt    = 8'(`EE_PROBE_CYCLES);
          state_next.powered   = 1'b1;
          state_next.tx_en     = 1'b1;
        end
        else
          state_next.seq_cnt = state_reg.seq_cnt + `CNT_W'(1);
      end
      rst_pwr_pkg::st_idle:
      begin
        if (sleep_request)
        begin
          state_next.seq   = rst_pwr_pkg::st_sleep;
          state_next.ready = 1'b0;
        end
        else if (host_soft_reset_bit)
        begin
          state_next.seq       = rst_pwr_pkg::st_host_host_soft_reset_bit;
          state_next.host_soft_reset_bit_bit  = 1'b1;
          state_next.hbi_rst_n = 1'b0;
          state_next.seq_cnt   = '0;
        end
      end
      rst_pwr_pkg::st_host_host_soft_reset_bit:
      begin
        // pll, phy, straps and exempt bits are left alone here
        if (state_reg.seq_cnt == `CNT_W'(`HOST_HOST_SOFT_RESET_BIT_CYCLES - 1))
        begin
          state_next.seq       = rst_pwr_pkg::st_idle;
          state_next.host_soft_reset_bit_bit  = 1'b0;
          state_next.hbi_rst_n = 1'b1;
          state_next.reload    = 1'b1;
          state_next.ee_busy   = 1'b1;
          state_next.ee_cnt    = 8'(`EE_PROBE_CYCLES);
        end
        else
          state_next.seq_cnt = state_reg.seq_cnt + `CNT_W'(1);
      end
      rst_pwr_pkg::st_sleep:
      begin
        // any data written to the wake test register wakes the device
        if (wake_test_write)
        begin
          state_next.seq     = rst_pwr_pkg::st_wake;
          state_next.seq_cnt = '0;
        end
      end
      rst_pwr_pkg::st_wake:
      begin
        if (state_reg.seq_cnt == `CNT_W'(WAKE_CYCLES - 1))
        begin
          state_next.seq   = rst_pwr_pkg::st_idle;
          state_next.ready = 1'b1;
        end
        else
          state_next.seq_cnt = state_reg.seq_cnt + `CNT_W'(1);
      end
      default:
        state_next.seq = rst_pwr_pkg::st_por;
    endcase

    // phy power and soft resets, skipped while the chip is held in reset
    if (state_reg.seq != rst_pwr_pkg::st_por)
    begin
      case (state_reg.phy)
        rst_pwr_pkg::phy_on:
        begin
          state_next.powered = 1'b1;
          state_next.tx_en   = 1'b1;
          if (phy_pdn_bit)
          begin
            state_next.phy     = rst_pwr_pkg::phy_gen_pdn;
            state_next.powered = 1'b0;
            state_next.tx_en   = 1'b0;
          end
          else if (phy_rst_write || phy_ctl_rst_write)
          begin
            state_next.phy         = rst_pwr_pkg::phy_in_reset;
            state_next.pmc_rst_bit = phy_rst_write;
            state_next.ctl_rst_bit = phy_ctl_rst_write;
            state_next.phy_rst_n   = 1'b0;
            state_next.phy_cnt     = '0;
          end
          else if (ed_pdn_bit && !energy_sync)
          begin
            state_next.phy     = rst_pwr_pkg::phy_ed_pdn;
            state_next.powered = 1'b0;
            state_next.tx_en   = 1'b0;
          end
        end
        rst_pwr_pkg::phy_gen_pdn:
        begin
          if (!phy_pdn_bit)
          begin
            // power returns and the phy resets itself on the way up
            state_next.phy       = rst_pwr_pkg::phy_in_reset;
            state_next.powered   = 1'b1;
            state_next.phy_rst_n = 1'b0;
            state_next.phy_cnt   = '0;
          end
        end
        rst_pwr_pkg::phy_ed_pdn:
        begin
          // leaving the mode or energy arriving both restore power; state kept
          if (!ed_pdn_bit || energy_sync)
          begin
            state_next.phy     = rst_pwr_pkg::phy_on;
            state_next.powered = 1'b1;
            state_next.tx_en   = 1'b1;
          end
          if (phy_pdn_bit)
          begin
            state_next.phy     = rst_pwr_pkg::phy_gen_pdn;
            state_next.powered = 1'b0;
            state_next.tx_en   = 1'b0;
          end
        end
        rst_pwr_pkg::phy_in_reset:
        begin
          // power-down overrides a running reset; the reset restarts on the way up
          if (phy_pdn_bit)
          begin
            state_next.phy     = rst_pwr_pkg::phy_gen_pdn;
            state_next.powered = 1'b0;
            state_next.tx_en   = 1'b0;
          end
          else if (state_reg.phy_cnt == `CNT_W'(`PHY_RST_CYCLES - 1))
          begin
            state_next.phy         = rst_pwr_pkg::phy_on;
            state_next.phy_rst_n   = 1'b1;
            state_next.pmc_rst_bit = 1'b0;
            state_next.ctl_rst_bit = 1'b0;
          end
          else
            state_next.phy_cnt = state_reg.phy_cnt + `CNT_W'(1);
        end
        default:
          state_next.phy = rst_pwr_pkg::phy_on;
      endcase
    end

    // energy wake flag: set wins over clear
    if (energy_flag_clear)
      state_next.energy_flag = 1'b0;
    if (state_reg.phy == rst_pwr_pkg::phy_ed_pdn && energy_sync && !state_reg.energy_prev)
      state_next.energy_flag = 1'b1;
    state_next.irq = state_next.energy_flag && energy_int_enable;

    // a low pin restarts the whole power-on sequence
    if (!pin_n_sync)
    begin
      state_next.seq       = rst_pwr_pkg::st_por;
      state_next.seq_cnt   = '0;
      state_next.ready     = 1'b0;
      state_next.hbi_rst_n = 1'b0;
      state_next.pll_rst_n = 1'b0;
      state_next.phy_rst_n = 1'b0;
      state_next.ee_busy   = 1'b0;
      state_next.host_soft_reset_bit_bit  = 1'b0;
      state_next.pmc_rst_bit = 1'b0;
      state_next.ctl_rst_bit = 1'b0;
      state_next.energy_flag = 1'b0;
      state_next.irq       = 1'b0;
      state_next.powered   = 1'b0;
      state_next.tx_en     = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg     <= '0;
      state_reg.seq <= rst_pwr_pkg::st_por;
      state_reg.phy <= rst_pwr_pkg::phy_in_reset;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs are flop bits; several resets share one flop by design
  assign hbi_rst_n              = state_reg.hbi_rst_n;
  assign mil_rst_n              = state_reg.hbi_rst_n;
  assign mac_rst_n              = state_reg.hbi_rst_n;
  assign pll_rst_n              = state_reg.pll_rst_n;
  assign exempt_rst_n           = state_reg.pll_rst_n;
  assign phy_rst_n              = state_reg.phy_rst_n;
  assign phy_powered            = state_reg.powered;
  assign phy_tx_enable          = state_reg.tx_en;
  assign ready                  = state_reg.ready;
  assign host_soft_reset_bit_rd = state_reg.host_soft_reset_bit_bit;
  assign phy_rst_bit_rd         = state_reg.pmc_rst_bit;
  assign phy_ctl_rst_bit_rd     = state_reg.ctl_rst_bit;
  assign eeprom_busy_flag       = state_reg.ee_busy;
  assign mac_addr_reload        = state_reg.reload;
  assign strap_latched          = state_reg.strap;
  assign energy_wake_int_flag   = state_reg.energy_flag;
  assign energy_irq             = state_reg.irq;
endmodule : rst_pwr_ctrl

// *** common/rst_pwr_cfg.svh ***
// timing counts and bit positions of the reset and power-down sequencer
`ifndef RST_PWR_CFG_SVH
`define RST_PWR_CFG_SVH
`define CLK_FREQ_HZ        20000000
`define POR_TIME_MS        22
`define POR_CYCLES         ((`POR_TIME_MS * `CLK_FREQ_HZ) / 1000)
`define HOST_HOST_SOFT_RESET_BIT_TIME_US  2
`define HOST_HOST_SOFT_RESET_BIT_CYCLES   ((`HOST_HOST_SOFT_RESET_BIT_TIME_US * `CLK_FREQ_HZ) / 1000000)
`define PHY_RST_TIME_US    100
`define PHY_RST_CYCLES     ((`PHY_RST_TIME_US * `CLK_FREQ_HZ) / 1000000)
`define WAKE_TIME_US       1000
`define WAKE_CYCLES        ((`WAKE_TIME_US * `CLK_FREQ_HZ) / 1000000)
`define EE_PROBE_CYCLES    64
`define CNT_W              20
`define PMC_PHY_RST_BIT    10
`define HWC_HOST_SOFT_RESET_BIT_BIT       0
`define PHY_CTL_RST_BIT    15
`define PHY_CTL_PDN_BIT    11
`define PHY_MODE_EDPD_BIT  13
`define EE_BUSY_BIT        31
`endif

// *** common/rst_pwr_pkg.sv ***
// types of the reset and power-down sequencer
package rst_pwr_pkg;
  typedef enum logic [2:0] {
    st_por,
    st_idle,
    st_host_host_soft_reset_bit,
    st_sleep,
    st_wake
  } seq_state_t;

  typedef enum logic [2:0] {
    phy_on,
    phy_gen_pdn,
    phy_ed_pdn,
    phy_in_reset
  } phy_state_t;
endpackage : rst_pwr_pkg

// *** core/sync_2ff.sv ***
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module sync_2ff
  #(parameter logic RST_VAL = 1'b0)
  (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // level
  input  wire logic d,
  output logic      q
  );

  logic meta_reg;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sync_2ff

// *** bench/rst_pwr_props_properties.sv ***
// concurrent checks on the ports of the reset and power-down sequencer
`timescale 1ns/1ps
`include "rst_pwr_cfg.svh"
module rst_pwr_props
  (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // inputs watched
  input wire logic hw_reset_input_n,
  input wire logic wake_test_write,
  input wire logic phy_pdn_bit,
  input wire logic energy_int_enable,
  // outputs watched
  input wire logic hbi_rst_n,
  input wire logic mil_rst_n,
  input wire logic mac_rst_n,
  input wire logic pll_rst_n,
  input wire logic exempt_rst_n,
  input wire logic phy_rst_n,
  input wire logic phy_powered,
  input wire logic phy_tx_enable,
  input wire logic ready,
  input wire logic host_soft_reset_bit_rd,
  input wire logic phy_rst_bit_rd,
  input wire logic eeprom_busy_flag,
  input wire logic mac_addr_reload,
  input wire logic energy_wake_int_flag,
  input wire logic energy_irq
  );
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // spans too long for a delay range are counted here instead
  localparam int unsigned PHY_LEN    = `PHY_RST_CYCLES;
  localparam int unsigned WAKE_LIMIT = (2 * `CLK_FREQ_HZ) / 1000;
  int unsigned phy_bit_cnt;
  int unsigned wake_cnt;
  logic        wake_armed;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      phy_bit_cnt <= 32'h0;
      wake_cnt    <= 32'h0;
      wake_armed  <= 1'b0;
    end
    else
    begin
      phy_bit_cnt <= phy_rst_bit_rd ? phy_bit_cnt + 32'h1 : 32'h0;
      if (ready || !pll_rst_n)
        wake_armed <= 1'b0;
      else if (wake_test_write)
        wake_armed <= 1'b1;
      wake_cnt <= (wake_armed && !ready) ? wake_cnt + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_pdn; ready && phy_pdn_bit |=> !phy_powered && !phy_tx_enable; endproperty
  a_pdn: assert property (p_pdn)
    else $error("phy powered in power-down");
  property p_up; ready && $fell(phy_pdn_bit) |-> ##[1:3] !phy_rst_n; endproperty
  a_up: assert property (p_up)
    else $error("no phy reset after power-up");
  property p_host_soft_reset_bit;
    $rose(host_soft_reset_bit_rd) |-> !hbi_rst_n && !mil_rst_n && !mac_rst_n
      && pll_rst_n && exempt_rst_n;
  endproperty
  a_host_soft_reset_bit: assert property (p_host_soft_reset_bit)
    else $error("soft reset hits wrong blocks");
  property p_slen;
    $rose(host_soft_reset_bit_rd) |-> ##39 host_soft_reset_bit_rd ##1 !host_soft_reset_bit_rd;
  endproperty
  a_slen: assert property (p_slen)
    else $error("soft reset bit length wrong");
  property p_ee; $fell(host_soft_reset_bit_rd) |-> eeprom_busy_flag && mac_addr_reload; endproperty
  a_ee: assert property (p_ee)
    else $error("no probe or reload after soft reset");
  property p_por; $rose(pll_rst_n) |-> ready && exempt_rst_n && mac_addr_reload; endproperty
  a_por: assert property (p_por)
    else $error("full reset release incomplete");
  property p_phy;
    $rose(phy_rst_bit_rd) |-> (!phy_rst_n && phy_rst_bit_rd)[*8];
  endproperty
  a_phy: assert property (p_phy)
    else $error("phy reset not applied with its bit");
  property p_phy_len; $fell(phy_rst_bit_rd) |-> phy_bit_cnt == PHY_LEN; endproperty
  a_phy_len: assert property (p_phy_len)
    else $error("phy reset bit length wrong");
  property p_tx; !phy_powered |-> !phy_tx_enable; endproperty
  a_tx: assert property (p_tx)
    else $error("transmit while powered down");
  property p_irq;
    energy_irq == (energy_wake_int_flag && $past(energy_int_enable));
  endproperty
  a_irq: assert property (p_irq)
    else $error("energy interrupt missing");
  property p_wake; wake_cnt < WAKE_LIMIT; endproperty
  a_wake: assert property (p_wake)
    else $error("ready late after wake");
  // two sync stages plus the state flop, so four low samples before the check
  property p_pin; !hw_reset_input_n[*4] |=> !ready && !pll_rst_n; endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset not applied");
  c_host_soft_reset_bit: cover property ($fell(host_soft_reset_bit_rd));
  c_wake: cover property (wake_test_write && !ready);
  c_irq: cover property ($rose(energy_irq));
endmodule : rst_pwr_props
bind rst_pwr_ctrl rst_pwr_props rst_pwr_props_inst (.*);

// *** bench/host_poll_model.sv ***
// host side: polls ready, gates mac address access on the probe
`timescale 1ns/1ps
module host_poll_model
  #(parameter int LIMIT = 2000000)
  (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // status seen
  input  wire logic ready,
  input  wire logic eeprom_busy_flag,
  input  wire logic phy_rst_n,
  // verdicts
  output logic      ready_err,
  output logic      mac_ok,
  output logic      link_ok
  );
  int wait_cnt;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      wait_cnt <= 0;
    else
      wait_cnt <= ready ? 0 : wait_cnt + 1;
  assign ready_err = (wait_cnt >= LIMIT);
  assign mac_ok    = ready && !eeprom_busy_flag;
  assign link_ok   = phy_rst_n;
endmodule : host_poll_model

// *** bench/test_rst_pwr_ctrl.sv ***
// self-checking bench of the reset and power-down sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_rst_pwr_ctrl;
  logic clock, nrst, hw_reset_input_n, line_energy_pin, strap_pins, host_soft_reset_bit;
  logic phy_rst_write, phy_ctl_rst_write, wake_test_write, sleep_request, energy_flag_clear;
  logic phy_pdn_bit, ed_pdn_bit, energy_int_enable, hbi_rst_n, mil_rst_n, mac_rst_n;
  logic pll_rst_n, exempt_rst_n, phy_rst_n, phy_powered, phy_tx_enable, ready;
  logic host_soft_reset_bit_rd, phy_rst_bit_rd, phy_ctl_rst_bit_rd, eeprom_busy_flag;
  logic mac_addr_reload, strap_latched, energy_wake_int_flag, energy_irq;
  logic ready_err, mac_ok, link_ok;
  logic [5:0] strobe_vec;
  int err_count, n_checks, cyc, n;
  int exp_len[$] = '{40, 2000, 2000};
  // short counts keep the run small; checks derive from these values
  rst_pwr_ctrl #(.POR_CYCLES(50), .WAKE_CYCLES(10)) rst_pwr_ctrl_inst (.*);
  host_poll_model host_poll_model_inst (.*);
  assign {host_soft_reset_bit, phy_rst_write, phy_ctl_rst_write, wake_test_write,
    sleep_request, energy_flag_clear} = strobe_vec;
  always #25 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic pulse(input logic [5:0] m);
    strobe_vec <= m;
    @(posedge clock);
    strobe_vec <= 6'h00;
    @(posedge clock);
  endtask : pulse
  task automatic wait_lvl(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 5000)
    begin
      @(posedge clock);
      k++;
    end
  endtask : wait_lvl
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(35));
    {clock, nrst, phy_pdn_bit, ed_pdn_bit} = 4'h0;
    strobe_vec = 6'h00;
    {energy_int_enable, hw_reset_input_n, line_energy_pin} = 3'h7;
    strap_pins = 1'($urandom);
    tick(8);
    nrst <= 1'b1;
    wait_lvl(ready, 1'b1, n);
    `CHK("por_len", 1'b1, 1'(n >= 50 && n < 60))
    `CHK("strap", strap_pins, strap_latched)
    `CHK("ee_busy", 1'b1, eeprom_busy_flag)
    wait_lvl(eeprom_busy_flag, 1'b0, n);
    tick(1);
    `CHK("mac_ok", 1'b1, mac_ok)
    $display("test power-on done");
    pulse(6'h20);
    `CHK("host_soft_reset_bit_set", 4'h1, {hbi_rst_n, mac_rst_n, pll_rst_n, phy_rst_n} ^ 4'h2)
    wait_lvl(host_soft_reset_bit_rd, 1'b0, n);
    `CHK("host_soft_reset_bit_len", exp_len.pop_front(), n)
    `CHK("host_soft_reset_bit_ee", 1'b1, eeprom_busy_flag)
    tick(80 + $urandom_range(0, 3));
    $display("test soft reset done");
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        pulse(6'h10);
      else
        pulse(6'h08);
      `CHK("phy_bit", 1'b1, k ? phy_ctl_rst_bit_rd : phy_rst_bit_rd)
      `CHK("phy_only", 2'h3, {hbi_rst_n, pll_rst_n})
      `CHK("link_wait", 1'b0, link_ok)
      wait_lvl(phy_rst_n, 1'b1, n);
      `CHK("phy_len", 1'b1, 1'(n + 1 >= exp_len[0] - 3 && n <= exp_len.pop_front() + 3))
      `CHK("phy_clr", 2'h0, {phy_ctl_rst_bit_rd, phy_rst_bit_rd})
    end
    `CHK("link_ok", 1'b1, link_ok)
    $display("test phy reset done");
    phy_pdn_bit <= 1'b1;
    tick(3);
    `CHK("gen_pdn", 2'h0, {phy_powered, phy_tx_enable})
    phy_pdn_bit <= 1'b0;
    wait_lvl(phy_rst_n, 1'b0, n);
    `CHK("pdn_rst", 1'b1, 1'(n < 4))
    wait_lvl(phy_rst_n, 1'b1, n);
    `CHK("pdn_up", 1'b1, phy_powered)
    line_energy_pin <= 1'b0;
    ed_pdn_bit <= 1'b1;
    tick(5);
    `CHK("ed_pdn", 2'h0, {phy_powered, phy_tx_enable})
    line_energy_pin <= 1'b1;
    tick(5);
    `CHK("ed_wake", 3'h7, {phy_powered, energy_wake_int_flag, energy_irq})
    pulse(6'h01);
    tick(2);
    `CHK("flag_clr", 2'h0, {energy_wake_int_flag, energy_irq})
    ed_pdn_bit <= 1'b0;
    line_energy_pin <= 1'b0;
    tick(5);
    `CHK("ed_off", 1'b1, phy_powered)
    $display("test power-down done");
    pulse(6'h02);
    `CHK("sleep", 1'b0, ready)
    pulse(6'h04);
    wait_lvl(ready, 1'b1, n);
    `CHK("wake", 1'b1, 1'(ready === 1'b1 && n == 10))
    hw_reset_input_n <= 1'b0;
    tick(5 + $urandom_range(0, 3));
    `CHK("pin_rst", 2'h0, {ready, pll_rst_n})
    hw_reset_input_n <= 1'b1;
    wait_lvl(ready, 1'b1, n);
    `CHK("pin_len", 1'b1, 1'(n >= 50 && n < 60))
    `CHK("host_wait", 1'b0, ready_err)
    $display("test pin reset done");
    finish_test();
  end
endmodule : test_rst_pwr_ctrl
